// ==== design/mcs_map.vh ====
// constants for the microcode sequencer: field positions, codes, reset values
`ifndef MCS_MAP_VH
`define MCS_MAP_VH
`define MCS_IW          48
`define MCS_DEPTH       512
`define MCS_ROWS        256
`define MCS_ROWW        96
`define MCS_AW          9
`define MCS_RAW         8
// ------------------------------------------------------------
// instruction field positions
// ------------------------------------------------------------
`define MCS_F_LCSEL     47
`define MCS_F_SHFT_HI   46
`define MCS_F_SHFT_LO   45
`define MCS_F_LIT       37
`define MCS_F_CNT       36
`define MCS_F_B_BUS_DEST_SELECT_HI   35
`define MCS_F_B_BUS_DEST_SELECT_LO   30
`define MCS_F_B_BUS_SOURCE_SELECT_HI   29
`define MCS_F_B_BUS_SOURCE_SELECT_LO   24
`define MCS_F_A_BUS_DEST_SELECT_HI   23
`define MCS_F_A_BUS_DEST_SELECT_LO   18
`define MCS_F_A_BUS_SOURCE_SELECT_HI   17
`define MCS_F_A_BUS_SOURCE_SELECT_LO   12
`define MCS_F_CSEL_HI   11
`define MCS_F_CSEL_LO   9
`define MCS_F_NA_HI     8
`define MCS_F_NA_LO     0
// ------------------------------------------------------------
// condition select codes
// ------------------------------------------------------------
`define MCS_C_FALSE     3'h0
`define MCS_C_CARRY     3'h1
`define MCS_C_OVF       3'h2
`define MCS_C_SIGN      3'h3
`define MCS_C_ZERO      3'h4
`define MCS_C_LCZ       3'h5
`define MCS_C_DLSB      3'h6
`define MCS_C_DMSB      3'h7
// ------------------------------------------------------------
// shift control codes
// ------------------------------------------------------------
`define MCS_S_NOP       2'h0
`define MCS_S_SHR       2'h1
`define MCS_S_SHL       2'h2
`define MCS_S_SWAP      2'h3
// ------------------------------------------------------------
// bus select codes used here
// ------------------------------------------------------------
`define MCS_SEL_DR0     6'h08
`define MCS_SEL_PC      6'h13
`define MCS_SEL_LIT0    6'h18
`define MCS_SEL_LIT7    6'h1f
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MCS_RST_PC      9'h000
`define MCS_RST_CNT     16'h0000
`define MCS_RST_DR0     16'h0000
`endif

// ==== design/mcs_microcode_sequencer.v ====
// microcode sequencer: next-address selection, field decode, counters, data register zero
//
// Operation
// - executes 48-bit instructions from a 512-word on-chip microcode store
// - each fetch reads an even/odd pair using upper eight address bits
// - store is 256 rows of 96 bits, both pair members in one read
// - odd word chosen only when address lsb is one and flag false
// - always-false condition is zero, so lsb picks even/odd directly
// - pc write overrides next address after one instruction of delay
// - delay-slot instruction executes even single-stepped but waits while frozen, unless a host pc load replaces it
// - select 0..4: false, carry, overflow, sign, zero from latched flags
// - select 5..7: selected counter zero, data register zero lsb, msb
// - alu flags latched on some ops; other three flags latched every executed cycle
// - four select fields decoded for two parallel bus transfers
// - decrement bit decrements the selected counter, otherwise it holds
// - decremented value and zero flag visible only next cycle
// - literal bit puts 9-bit literal on a bus low bits, upper seven zero
// - b bus source decode offers 3-bit constants in any instruction
// - shift field: nop, shift right sign-extend, shift left zero-fill, swap
// - byte swap applies only to values written into data register zero
// - counter-select bit: zero picks counter zero, one picks counter one
`timescale 1ns/1ps
`default_nettype none
`include "mcs_map.vh"
module mcs_microcode_sequencer #(
  parameter integer DW = 16
) (
  input  wire            clk,          // processor clock
  input  wire            rst,          // synchronous reset, active high
  input  wire            halt,         // processor halted
  input  wire            freeze,       // processor frozen
  input  wire            step,         // single-step pulse while halted
  input  wire            load_we,      // microcode store write
  input  wire [8:0]      load_addr,    // microcode store write address
  input  wire [47:0]     load_data,    // microcode store write data
  input  wire            pc_we,        // host pc load while halted
  input  wire [8:0]      pc_wdata,     // host pc value
  input  wire [DW-1:0]   a_bus_in,     // a bus value from other sources
  input  wire [DW-1:0]   b_bus_in,     // b bus value from other sources
  input  wire            alu_flag_we,  // alu op updates flags
  input  wire [3:0]      alu_flags_in, // carry, overflow, sign, zero
  input  wire            cnt_we0,      // bus write to counter zero
  input  wire            cnt_we1,      // bus write to counter one
  output reg  [8:0]      pc_reg,       // address of executing instruction
  output reg  [47:0]     instr_reg,    // executing instruction word
  output reg  [5:0]      a_src_reg,    // decoded a bus driver
  output reg  [5:0]      a_dst_reg,    // decoded a bus latch
  output reg  [5:0]      b_src_reg,    // decoded b bus driver
  output reg  [5:0]      b_dst_reg,    // decoded b bus latch
  output reg             lit_en_reg,   // a bus carries literal
  output reg  [DW-1:0]   a_bus_reg,    // a bus value
  output reg  [DW-1:0]   b_bus_reg,    // b bus value
  output reg  [DW-1:0]   dr0_reg,      // data register zero
  output reg  [DW-1:0]   cnt0_reg,     // loop counter zero
  output reg  [DW-1:0]   cnt1_reg,     // loop counter one
  output reg  [3:0]      alu_flag_reg, // latched alu flags
  output reg             lcz_flag_reg, // loop_counter_zero_flag
  output reg             dlsb_reg,     // data register zero lsb flag
  output reg             dmsb_reg      // data register zero msb flag
);
  // ------------------------------------------------------------
  // microcode store
  // ------------------------------------------------------------
  reg [`MCS_ROWW-1:0] store_mem [0:`MCS_ROWS-1];
  wire [47:0] cur = instr_reg;
  wire [8:0]  next_address_field     = cur[`MCS_F_NA_HI:`MCS_F_NA_LO];
  wire [2:0]  condition_select_field = cur[`MCS_F_CSEL_HI:`MCS_F_CSEL_LO];
  wire [5:0]  a_bus_source_select    = cur[`MCS_F_A_BUS_SOURCE_SELECT_HI:`MCS_F_A_BUS_SOURCE_SELECT_LO];
  wire [5:0]  a_bus_dest_select      = cur[`MCS_F_A_BUS_DEST_SELECT_HI:`MCS_F_A_BUS_DEST_SELECT_LO];
  wire [5:0]  b_bus_source_select    = cur[`MCS_F_B_BUS_SOURCE_SELECT_HI:`MCS_F_B_BUS_SOURCE_SELECT_LO];
  wire [5:0]  b_bus_dest_select      = cur[`MCS_F_B_BUS_DEST_SELECT_HI:`MCS_F_B_BUS_DEST_SELECT_LO];
  wire        counter_select_bit     = cur[`MCS_F_LCSEL];
  wire [1:0]  shft                   = cur[`MCS_F_SHFT_HI:`MCS_F_SHFT_LO];
  wire        lit_bit                = cur[`MCS_F_LIT];
  wire        dec_bit                = cur[`MCS_F_CNT];

  // ------------------------------------------------------------
  // condition select
  // ------------------------------------------------------------
  // alu flag bits: 3 carry, 2 overflow, 1 sign, 0 zero
  reg cond;
  always @* begin
    case (condition_select_field)
      `MCS_C_FALSE: cond = 1'b0;
      `MCS_C_CARRY: cond = alu_flag_reg[3];
      `MCS_C_OVF:   cond = alu_flag_reg[2];
      `MCS_C_SIGN:  cond = alu_flag_reg[1];
      `MCS_C_ZERO:  cond = alu_flag_reg[0];
      `MCS_C_LCZ:   cond = lcz_flag_reg;
      `MCS_C_DLSB:  cond = dlsb_reg;
      `MCS_C_DMSB:  cond = dmsb_reg;
      default:      cond = 1'b0;
    endcase
  end

  // literal eats the condition bits, so no branch test then
  wire cond_eff = lit_bit ? 1'b0 : cond;

  // ------------------------------------------------------------
  // next address
  // ------------------------------------------------------------
  reg        pend_reg;
  reg  [8:0] pend_addr_reg;
  wire       pc_load  = (a_bus_dest_select == `MCS_SEL_PC) || (b_bus_dest_select == `MCS_SEL_PC);
  // a pending jump bypasses the lsb and condition pick entirely
  wire [8:0] tgt       = pend_reg ? pend_addr_reg : next_address_field;
  wire       pick_odd  = tgt[0] & ~cond_eff & ~pend_reg;
  wire [8:0] next_pc   = pend_reg ? pend_addr_reg : {tgt[8:1], pick_odd};
  wire [95:0] row      = store_mem[next_pc[8:1]];
  wire [47:0] fetched  = next_pc[0] ? row[95:48] : row[47:0];

  // runs when free, or on a step; a pending slot completes on a step too
  wire run = ~freeze & (~halt | step);

  // ------------------------------------------------------------
  // bus value decode
  // ------------------------------------------------------------
  // literal takes the a source and condition bits as one 9-bit value
  reg [DW-1:0] a_val;
  reg [DW-1:0] b_val;
  always @* begin
    if (lit_bit) begin
      a_val = {{(DW-9){1'b0}}, a_bus_source_select, condition_select_field};
    end else if (a_bus_source_select == `MCS_SEL_DR0) begin
      a_val = dr0_reg;
    end else begin
      a_val = a_bus_in;
    end
    if (b_bus_source_select >= `MCS_SEL_LIT0 && b_bus_source_select <= `MCS_SEL_LIT7) begin
      b_val = {{(DW-3){1'b0}}, b_bus_source_select[2:0]};
    end else if (b_bus_source_select == `MCS_SEL_DR0) begin
      b_val = dr0_reg;
    end else begin
      b_val = b_bus_in;
    end
  end

  // ------------------------------------------------------------
  // data register zero
  // ------------------------------------------------------------
  // a load wins over a shift; a swap only touches the incoming value
  wire dr0_a = (a_bus_dest_select == `MCS_SEL_DR0);
  wire dr0_b = (b_bus_dest_select == `MCS_SEL_DR0);
  wire [DW-1:0] dr0_in = dr0_a ? a_val : b_val;
  reg  [DW-1:0] dr0_next;
  always @* begin
    dr0_next = dr0_reg;
    case (shft)
      `MCS_S_SHR:  dr0_next = (dr0_a | dr0_b) ? dr0_in : {dr0_reg[DW-1], dr0_reg[DW-1:1]};
      `MCS_S_SHL:  dr0_next = (dr0_a | dr0_b) ? dr0_in : {dr0_reg[DW-2:0], 1'b0};
      `MCS_S_SWAP: dr0_next = (dr0_a | dr0_b) ? {dr0_in[7:0], dr0_in[DW-1:8]} : dr0_reg;
      default:     dr0_next = (dr0_a | dr0_b) ? dr0_in : dr0_reg;
    endcase
  end

  // ------------------------------------------------------------
  // loop counters
  // ------------------------------------------------------------
  // a b bus load of a counter wins over its decrement
  reg [DW-1:0] cnt0_next;
  reg [DW-1:0] cnt1_next;
  always @* begin
    cnt0_next = cnt0_reg;
    cnt1_next = cnt1_reg;
    if (dec_bit && !counter_select_bit) begin
      cnt0_next = cnt0_reg - {{(DW-1){1'b0}}, 1'b1};
    end
    if (dec_bit && counter_select_bit) begin
      cnt1_next = cnt1_reg - {{(DW-1){1'b0}}, 1'b1};
    end
    if (cnt_we0) begin
      cnt0_next = b_val;
    end
    if (cnt_we1) begin
      cnt1_next = b_val;
    end
  end
  // zero flag follows the counter that the instruction being fetched selects
  wire [DW-1:0] sel_next = fetched[`MCS_F_LCSEL] ? cnt1_next : cnt0_next;

  // ------------------------------------------------------------
  // host program counter load
  // ------------------------------------------------------------
  // only while halted and not running, so it never races an executing edge
  wire          host_load = pc_we & halt & ~run;
  wire [95:0]   host_row  = store_mem[pc_wdata[8:1]];
  wire [47:0]   host_word = pc_wdata[0] ? host_row[95:48] : host_row[47:0];
  wire [DW-1:0] host_cnt  = host_word[`MCS_F_LCSEL] ? cnt1_reg : cnt0_reg;
  // pc write value comes from the bus the loading instruction drives now
  wire [DW-1:0] pc_val    = (a_bus_dest_select == `MCS_SEL_PC) ? a_val : b_val;

  // ------------------------------------------------------------
  // microcode store write
  // ------------------------------------------------------------
  // one half of a row per write, picked by the address lsb
  always @(posedge clk) begin
    if (load_we) begin
      if (load_addr[0]) begin
        store_mem[load_addr[8:1]][95:48] <= load_data;
      end else begin
        store_mem[load_addr[8:1]][47:0] <= load_data;
      end
    end
  end

  // ------------------------------------------------------------
  // program counter, instruction, pending load
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pc_reg        <= `MCS_RST_PC;
      instr_reg     <= 48'h000000000000;
      pend_reg      <= 1'b0;
      pend_addr_reg <= `MCS_RST_PC;
    end else if (run) begin
      pc_reg        <= next_pc;
      instr_reg     <= fetched;
      pend_reg      <= pc_load;
      pend_addr_reg <= pc_val[8:0];
    end else if (host_load) begin
      // a host load replaces any jump still pending
      pc_reg        <= pc_wdata;
      instr_reg     <= host_word;
      pend_reg      <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // loop counters
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      cnt0_reg <= `MCS_RST_CNT;
      cnt1_reg <= `MCS_RST_CNT;
    end else if (run) begin
      cnt0_reg <= cnt0_next;
      cnt1_reg <= cnt1_next;
    end
  end

  // ------------------------------------------------------------
  // data register zero
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      dr0_reg <= `MCS_RST_DR0;
    end else if (run) begin
      dr0_reg <= dr0_next;
    end
  end

  // ------------------------------------------------------------
  // condition flags
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      alu_flag_reg <= 4'h0;
      lcz_flag_reg <= 1'b1;
      dlsb_reg     <= 1'b0;
      dmsb_reg     <= 1'b0;
    end else if (run) begin
      if (alu_flag_we) begin
        alu_flag_reg <= alu_flags_in;
      end
      // the other three flags refresh on every executed cycle
      lcz_flag_reg <= (sel_next == {DW{1'b0}});
      dlsb_reg     <= dr0_next[0];
      dmsb_reg     <= dr0_next[DW-1];
    end else if (host_load) begin
      // a loaded word may select the other counter for its zero test
      lcz_flag_reg <= (host_cnt == {DW{1'b0}});
    end
  end

  // ------------------------------------------------------------
  // decoded selects and bus values
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      a_src_reg  <= 6'h00;
      a_dst_reg  <= 6'h00;
      b_src_reg  <= 6'h00;
      b_dst_reg  <= 6'h00;
      lit_en_reg <= 1'b0;
      a_bus_reg  <= {DW{1'b0}};
      b_bus_reg  <= {DW{1'b0}};
    end else if (run) begin
      a_src_reg  <= fetched[`MCS_F_A_BUS_SOURCE_SELECT_HI:`MCS_F_A_BUS_SOURCE_SELECT_LO];
      a_dst_reg  <= fetched[`MCS_F_A_BUS_DEST_SELECT_HI:`MCS_F_A_BUS_DEST_SELECT_LO];
      b_src_reg  <= fetched[`MCS_F_B_BUS_SOURCE_SELECT_HI:`MCS_F_B_BUS_SOURCE_SELECT_LO];
      b_dst_reg  <= fetched[`MCS_F_B_BUS_DEST_SELECT_HI:`MCS_F_B_BUS_DEST_SELECT_LO];
      lit_en_reg <= lit_bit;
      a_bus_reg  <= a_val;
      b_bus_reg  <= b_val;
    end else if (host_load) begin
      // selects always describe the word held in instr_reg
      a_src_reg  <= host_word[`MCS_F_A_BUS_SOURCE_SELECT_HI:`MCS_F_A_BUS_SOURCE_SELECT_LO];
      a_dst_reg  <= host_word[`MCS_F_A_BUS_DEST_SELECT_HI:`MCS_F_A_BUS_DEST_SELECT_LO];
      b_src_reg  <= host_word[`MCS_F_B_BUS_SOURCE_SELECT_HI:`MCS_F_B_BUS_SOURCE_SELECT_LO];
      b_dst_reg  <= host_word[`MCS_F_B_BUS_DEST_SELECT_HI:`MCS_F_B_BUS_DEST_SELECT_LO];
    end
  end
endmodule
`default_nettype wire

// ==== bench/mcs_microcode_sequencer_monitor.sv ====
// port checker for the microcode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "mcs_map.vh"
module mcs_microcode_sequencer_monitor #(
  parameter integer DW = 16
) (
  input wire logic          clk,          // clock
  input wire logic          rst,          // sync reset
  input wire logic          halt,         // halted
  input wire logic          freeze,       // frozen
  input wire logic          step,         // single step
  input wire logic          pc_we,        // host pc load
  input wire logic          cnt_we0,      // counter zero load
  input wire logic          cnt_we1,      // counter one load
  input wire logic [8:0]    pc_reg,       // current address
  input wire logic [47:0]   instr_reg,    // current word
  input wire logic [DW-1:0] a_bus_reg,    // a bus
  input wire logic [DW-1:0] b_bus_reg,    // b bus
  input wire logic [DW-1:0] dr0_reg,      // data reg zero
  input wire logic [DW-1:0] cnt0_reg,     // counter zero
  input wire logic [DW-1:0] cnt1_reg,     // counter one
  input wire logic [3:0]    alu_flag_reg, // alu flags
  input wire logic          lcz_flag_reg, // counter zero flag
  input wire logic          dlsb_reg,     // lsb flag
  input wire logic          dmsb_reg      // msb flag
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic          run, pend_reg, pend_b_reg, odd_w, nodst;
  logic [7:0]    cvec;
  logic [8:0]    lit_w, pcsrc_w;
  logic [2:0]    bc_w;
  logic [DW-1:0] shr_w;
  assign run     = !freeze && (!halt || step);
  assign cvec    = {dmsb_reg, dlsb_reg, lcz_flag_reg, alu_flag_reg[0], alu_flag_reg[1],
                    alu_flag_reg[2], alu_flag_reg[3], 1'b0};
  assign odd_w   = instr_reg[0] && (instr_reg[37] || !cvec[instr_reg[11:9]]);
  assign nodst   = instr_reg[23:18] != `MCS_SEL_DR0 && instr_reg[35:30] != `MCS_SEL_DR0;
  assign lit_w   = instr_reg[17:9];
  assign bc_w    = instr_reg[26:24];
  assign shr_w   = {dr0_reg[DW-1], dr0_reg[DW-1:1]};
  assign pcsrc_w = pend_b_reg ? b_bus_reg[8:0] : a_bus_reg[8:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg   <= 1'b0;
      pend_b_reg <= 1'b0;
    end else if (run) begin
      pend_reg   <= instr_reg[23:18] == `MCS_SEL_PC || instr_reg[35:30] == `MCS_SEL_PC;
      pend_b_reg <= instr_reg[23:18] != `MCS_SEL_PC;
    end else if (pc_we && halt) begin
      pend_reg   <= 1'b0;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_hold_state: assert property (
    !run && !pc_we && !cnt_we0 && !cnt_we1 |=> $stable(pc_reg) && $stable(cnt1_reg)
    && $stable(cnt0_reg) && $stable(dr0_reg))
    else $error("state moved while stopped");
  a_pair_row: assert property (
    run && !pend_reg |=> pc_reg[8:1] == $past(instr_reg[8:1])) else $error("bad row");
  a_odd_pick: assert property (
    run && !pend_reg |=> pc_reg[0] == $past(odd_w)) else $error("bad even/odd pick");
  a_pc_delay: assert property (
    run && pend_reg |=> pc_reg == $past(pcsrc_w)) else $error("bad delayed pc load");
  a_dec_one: assert property (
    run && instr_reg[36] && instr_reg[47] && !cnt_we0 && !cnt_we1
    |=> cnt1_reg == $past(cnt1_reg) - 1'b1 && $stable(cnt0_reg)) else $error("bad decrement");
  a_lit_abus: assert property (
    run && instr_reg[37] |=> a_bus_reg == $past(lit_w)) else $error("bad a literal");
  a_b_const: assert property (
    run && instr_reg[29:27] == 3'h3 |=> b_bus_reg == $past(bc_w)) else $error("bad b const");
  a_shr_sign: assert property (
    run && nodst && instr_reg[46:45] == `MCS_S_SHR |=> dr0_reg == $past(shr_w))
    else $error("bad shift right");
  a_swap_hold: assert property (
    run && nodst && instr_reg[46:45] == `MCS_S_SWAP |=> $stable(dr0_reg))
    else $error("held value swapped");
endmodule
`default_nettype wire

// ==== bench/mcs_microcode_sequencer_tb.sv ====
// self-checking testbench for the microcode sequencer
`timescale 1ns/1ps
`default_nettype none
module mcs_microcode_sequencer_tb;
  logic        clk, rst, halt, freeze, step, load_we, pc_we, alu_flag_we;
  logic [8:0]  load_addr, pc_wdata;
  logic [47:0] load_data;
  logic [3:0]  alu_flags_in;
  wire  [8:0]  pc_reg;
  wire  [47:0] instr_reg;
  wire  [15:0] a_bus_reg, b_bus_reg, dr0_reg, cnt0_reg, cnt1_reg;
  wire  [3:0]  alu_flag_reg;
  wire         lcz_flag_reg, dlsb_reg, dmsb_reg;
  wire  [5:0]  a_src_reg, a_dst_reg, b_src_reg, b_dst_reg;
  wire         lit_en_reg;
  int          errors = 0, n_tests = 0, c;
  logic [8:0]  tmask = 9'h12a;
  logic [15:0] dexp [0:4] = '{16'h8000, 16'hc000, 16'h8000, 16'h8000, 16'h0005};
  mcs_microcode_sequencer #(.DW(16)) DUT (
    .clk(clk), .rst(rst), .halt(halt), .freeze(freeze), .step(step), .load_we(load_we),
    .load_addr(load_addr), .load_data(load_data), .pc_we(pc_we), .pc_wdata(pc_wdata),
    .a_bus_in(16'h1234), .b_bus_in(16'h5678), .alu_flag_we(alu_flag_we),
    .alu_flags_in(alu_flags_in), .cnt_we0(1'b0), .cnt_we1(1'b0), .pc_reg(pc_reg),
    .instr_reg(instr_reg), .a_src_reg(a_src_reg), .a_dst_reg(a_dst_reg),
    .b_src_reg(b_src_reg), .b_dst_reg(b_dst_reg),
    .lit_en_reg(lit_en_reg), .a_bus_reg(a_bus_reg), .b_bus_reg(b_bus_reg), .dr0_reg(dr0_reg),
    .cnt0_reg(cnt0_reg), .cnt1_reg(cnt1_reg), .alu_flag_reg(alu_flag_reg),
    .lcz_flag_reg(lcz_flag_reg), .dlsb_reg(dlsb_reg), .dmsb_reg(dmsb_reg));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [47:0] d);
    load_we = 1'b1;
    load_addr = a;
    load_data = d;
    tick;
  endtask
  task automatic setpc(input logic [8:0] a);
    pc_we = 1'b1;
    pc_wdata = a;
    tick;
    pc_we = 1'b0;
    tick;
  endtask
  task automatic stp;
    tick;
    step = 1'b1;
    tick;
    step = 1'b0;
  endtask
  task automatic stop_test;
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    stop_test;
  end
  initial begin
    {rst, halt} = 2'h3;
    {freeze, step, load_we, pc_we, alu_flag_we} = 5'h00;
    {load_addr, load_data, pc_wdata, alu_flags_in} = '0;
    repeat (2) tick;
    rst = 1'b0;
    chk(lcz_flag_reg, 48'h1);
    for (c = 0; c < 8; c++)
      wr(9'h020 + c[8:0], {36'h0, c[2:0], 9'h041});
    wr(9'h028, 48'h0000_0000_0040);
    wr(9'h040, 48'h0000_0000_0040);
    wr(9'h041, 48'h0000_0000_0141);
    wr(9'h030, 48'h8010_0000_0a31);
    wr(9'h031, 48'h0000_0000_0000);
    wr(9'h010, 48'h0020_004c_a055);
    wr(9'h055, 48'h0000_0000_0066);
    wr(9'h050, 48'h0000_0004_5050);
    wr(9'h060, 48'h6020_0021_0062);
    wr(9'h062, 48'h2000_0000_0064);
    wr(9'h064, 48'h4000_0000_0066);
    wr(9'h066, 48'h6000_0000_0068);
    wr(9'h068, 48'h0002_1d00_0068);
    load_we = 1'b0;
    setpc(9'h050);
    alu_flags_in = 4'ha;
    alu_flag_we = 1'b1;
    stp;
    alu_flag_we = 1'b0;
    alu_flags_in = 4'h5;
    chk(alu_flag_reg, 48'ha);
    for (c = 0; c < 9; c++) begin
      setpc(9'h020 + c[8:0]);
      stp;
      chk(pc_reg, tmask[c] ? 48'h040 : 48'h041);
      chk(instr_reg, tmask[c] ? 48'h040 : 48'h141);
    end
    setpc(9'h030);
    stp;
    chk(pc_reg, 48'h030);
    chk(cnt1_reg, 48'hffff);
    chk(cnt0_reg, 48'h0);
    chk(lcz_flag_reg, 48'h0);
    freeze = 1'b1;
    stp;
    chk(cnt1_reg, 48'hffff);
    freeze = 1'b0;
    stp;
    chk(pc_reg, 48'h031);
    chk(cnt1_reg, 48'hfffe);
    setpc(9'h010);
    stp;
    chk(pc_reg, 48'h055);
    chk(a_bus_reg, 48'h0050);
    chk(lit_en_reg, 48'h1);
    freeze = 1'b1;
    stp;
    chk(pc_reg, 48'h055);
    freeze = 1'b0;
    stp;
    chk(pc_reg, 48'h050);
    chk(lit_en_reg, 48'h0);
    chk(a_src_reg, 48'h05);
    chk(a_dst_reg, 48'h01);
    setpc(9'h060);
    halt = 1'b0;
    for (c = 0; c < 5; c++) begin
      tick;
      chk(dr0_reg, dexp[c]);
    end
    halt = 1'b1;
    chk(b_bus_reg, 48'h0005);
    chk(b_src_reg, 48'h1d);
    chk(b_dst_reg, 48'h08);
    chk(alu_flag_reg, 48'ha);
    stop_test;
  end
endmodule
bind mcs_microcode_sequencer mcs_microcode_sequencer_monitor #(.DW(DW)) u_mon (
  .clk(clk), .rst(rst), .halt(halt), .freeze(freeze), .step(step), .pc_we(pc_we),
  .cnt_we0(cnt_we0), .cnt_we1(cnt_we1), .pc_reg(pc_reg), .instr_reg(instr_reg),
  .a_bus_reg(a_bus_reg), .b_bus_reg(b_bus_reg), .dr0_reg(dr0_reg), .cnt0_reg(cnt0_reg),
  .cnt1_reg(cnt1_reg), .alu_flag_reg(alu_flag_reg), .lcz_flag_reg(lcz_flag_reg),
  .dlsb_reg(dlsb_reg), .dmsb_reg(dmsb_reg));
`default_nettype wire
